/* File: logic/tsff_consts.svh */
// Timing constants for the thermal shutdown and fault flag block
`ifndef TSFF_CONSTS_SVH
`define TSFF_CONSTS_SVH

// Clock period in picoseconds (200 MHz)
`define TSFF_CLK_PERIOD_PS 5000
// Total fault frame period in nanoseconds
`define TSFF_FRAME_NS 36000
// Number of portions in one frame: alert, channel one, channel two
`define TSFF_PORTIONS 3
// Cycles in one frame, rounded down
`define TSFF_FRAME_CYC ((`TSFF_FRAME_NS * 1000) / `TSFF_CLK_PERIOD_PS)
// Cycles in one portion
`define TSFF_PORTION_CYC (`TSFF_FRAME_CYC / `TSFF_PORTIONS)

`endif

/* File: logic/tsff_pkg.sv */
// Types shared by the thermal shutdown and fault flag block
`default_nettype none
package tsff_pkg;
    // Fault frame sequencer phases
    typedef enum logic [1:0] {
        TSFF_IDLE,
        TSFF_ALERT,
        TSFF_CH1,
        TSFF_CH2
    } tsff_phase_t;
endpackage
`default_nettype wire

/* File: logic/tsff_sync.sv */
// Two-flop synchroniser for a bus of pin inputs
`default_nettype none
module tsff_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } tsff_sync_state_t;

    tsff_sync_state_t st;
    tsff_sync_state_t next_st;

    // Shift chain, first stage only feeds second
    always_comb begin
        next_st.meta = d;
        next_st.sync = st.meta;
        if (!rst_n) begin
            next_st = '0;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    assign q = st.sync;
endmodule
`default_nettype wire

/* File: logic/tsff_top.sv */
// Die overheat shutdown and fault flag frame generator
//
// Contract
// R1 - Overheat above upper trip shuts chip down
// R2 - Detection armed: supply valid, any enable
// R3 - All PWM outputs high impedance in shutdown
// R4 - Recover below lower level, restart power-up
// R5 - Repeating frame: alert, flag one, flag two
// R6 - Flag portion high while its fault present (code latches the fault from frame start and holds the portion high)
// R7 - Frames start on fault, stop after power-good
// R8 - Frame in progress completes before stopping
// R9 - Idle pin low; portion width parameterised
`include "tsff_consts.svh"
`default_nettype none
module tsff_top
    import tsff_pkg::*;
#(
    parameter int PWM_CH = 4,
    parameter int PORTION_CYC = `TSFF_PORTION_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Supply and enable status pins
    input wire logic internal_supply_valid,
    input wire logic enable_ch1,
    input wire logic enable_ch2,
    // Die temperature comparators (above upper trip, below lower level)
    input wire logic temp_above_trip,
    input wire logic temp_below_recover,
    // Confirmed faults per channel and power-good
    input wire logic fault_ch1,
    input wire logic fault_ch2,
    input wire logic power_good_out,
    // PWM requests from the regulation loop
    input wire logic [PWM_CH-1:0] pwm_in,
    // PWM pins, two signals each (data and output enable)
    output logic [PWM_CH-1:0] pwm_out,
    output logic [PWM_CH-1:0] pwm_oe,
    // Chip-wide shutdown and power-up restart pulse
    output logic die_overheat_shutdown,
    output logic power_up_restart,
    // Fault indicator pin and its alert-portion flag
    output logic fault_pin,
    output logic alert_portion
);
    localparam int CW = $clog2(PORTION_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(PORTION_CYC - 1);

    typedef struct packed {
        logic shutdown;
        logic restart;
        logic active;
        logic flag1;
        logic flag2;
        tsff_phase_t phase;
        logic [CW-1:0] cnt;
        logic [PWM_CH-1:0] pwm;
        logic [PWM_CH-1:0] oe;
        logic pin;
    } tsff_state_t;

    tsff_state_t st;
    tsff_state_t next_st;

    logic [7:0] raw;
    logic [7:0] syn;
    logic armed;
    logic any_fault;
    logic pg;

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    assign raw = {internal_supply_valid, enable_ch1, enable_ch2,
                  temp_above_trip, temp_below_recover, fault_ch1,
                  fault_ch2, power_good_out};

    tsff_sync #(.WIDTH(8)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(raw),
        .q(syn)
    );

    // R2 armed detection
    assign armed = syn[7] && (syn[6] || syn[5]);
    assign any_fault = syn[2] || syn[1];
    assign pg = syn[0];

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.restart = 1'b0;

        // R1 shutdown on overheat
        if (!st.shutdown && armed && syn[4]) begin
            next_st.shutdown = 1'b1;
        end
        // R4 automatic recovery
        if (st.shutdown && syn[3]) begin
            next_st.shutdown = 1'b0;
            next_st.restart = 1'b1;
        end

        // R3 tri-state PWM pins
        if (next_st.shutdown) begin
            next_st.oe = '0;
            next_st.pwm = '0;
        end else begin
            next_st.oe = '1;
            next_st.pwm = pwm_in;
        end

        // R7 start on confirmed fault, stop once power-good returns
        if (any_fault) begin
            next_st.active = 1'b1;
        end else if (pg) begin
            next_st.active = 1'b0;
        end

        // R5 frame sequencer
        case (st.phase)
            TSFF_IDLE: begin
                next_st.cnt = '0;
                if (next_st.active) begin
                    next_st.phase = TSFF_ALERT;
                end
            end
            TSFF_ALERT: begin
                // R6 latch flags at frame start
                next_st.flag1 = st.flag1 | syn[2];
                next_st.flag2 = st.flag2 | syn[1];
                next_st.cnt = st.cnt + CW'(1);
                if (st.cnt == LAST) begin
                    next_st.cnt = '0;
                    next_st.phase = TSFF_CH1;
                end
            end
            TSFF_CH1: begin
                next_st.flag1 = st.flag1 | syn[2];
                next_st.cnt = st.cnt + CW'(1);
                if (st.cnt == LAST) begin
                    next_st.cnt = '0;
                    next_st.phase = TSFF_CH2;
                end
            end
            TSFF_CH2: begin
                next_st.flag2 = st.flag2 | syn[1];
                next_st.cnt = st.cnt + CW'(1);
                if (st.cnt == LAST) begin
                    // R8 frame ends whole before stopping
                    next_st.cnt = '0;
                    next_st.flag1 = syn[2];
                    next_st.flag2 = syn[1];
                    next_st.phase = next_st.active ? TSFF_ALERT : TSFF_IDLE;
                end
            end
            default: begin
                next_st.phase = TSFF_IDLE;
                next_st.cnt = '0;
            end
        endcase

        // R6 flag portions high once fault latched this frame; R9 idle low
        case (next_st.phase)
            TSFF_ALERT: next_st.pin = 1'b1;
            TSFF_CH1: next_st.pin = next_st.flag1;
            TSFF_CH2: next_st.pin = next_st.flag2;
            default: next_st.pin = 1'b0;
        endcase
        if (next_st.phase == TSFF_IDLE) begin
            next_st.flag1 = 1'b0;
            next_st.flag2 = 1'b0;
        end

        if (!rst_n) begin
            next_st = '0;
            next_st.phase = TSFF_IDLE;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign pwm_out = st.pwm;
    assign pwm_oe = st.oe;
    assign die_overheat_shutdown = st.shutdown;
    assign power_up_restart = st.restart;
    assign fault_pin = st.pin;
    assign alert_portion = (st.phase == TSFF_ALERT);
endmodule
`default_nettype wire

/* File: tb/tsff_monitor.sv */
// Fault pin monitor model
`default_nettype none
module tsff_monitor (
    // Clock
    input wire logic sys_clk,
    // Fault pin and last twelve samples, oldest on top
    input wire logic fault_pin,
    output logic [11:0] frame
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge sys_clk) begin
        frame <= {frame[10:0], fault_pin};
    end
endmodule
`default_nettype wire

/* File: tb/tsff_assertions.sv */
// Checker for the shutdown and fault frame block
`default_nettype none
module tsff_assertions #(
    parameter int PWM_CH = 4,
    parameter int PORTION_CYC = 4
) (
    // Clock, reset and status inputs
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic internal_supply_valid,
    input wire logic enable_ch1,
    input wire logic enable_ch2,
    input wire logic temp_above_trip,
    input wire logic temp_below_recover,
    // Outputs watched
    input wire logic [PWM_CH-1:0] pwm_oe,
    input wire logic die_overheat_shutdown,
    input wire logic power_up_restart,
    input wire logic fault_pin,
    input wire logic alert_portion
);
    localparam int GAP = 2 * PORTION_CYC;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    shut_entry_a: assert property ($rose(die_overheat_shutdown) |->
        $past(temp_above_trip, 2) && $past(internal_supply_valid, 2) &&
        ($past(enable_ch1, 2) || $past(enable_ch2, 2)))
        else $error("shutdown without armed trip");
    pwm_hiz_a: assert property (die_overheat_shutdown &&
        $past(die_overheat_shutdown) |-> pwm_oe == '0)
        else $error("pwm driven in shutdown");
    shut_exit_a: assert property ($fell(die_overheat_shutdown) |->
        $past(temp_below_recover, 2)) else $error("early recovery");
    restart_cause_a: assert property ($fell(die_overheat_shutdown) |->
        ##[0:1] power_up_restart) else $error("no restart pulse");
    restart_pulse_a: assert property (power_up_restart |=>
        !power_up_restart) else $error("restart pulse too long");
    alert_high_a: assert property (alert_portion |-> fault_pin)
        else $error("pin low in alert portion");
    alert_len_a: assert property ($fell(alert_portion) |->
        $past(alert_portion, PORTION_CYC) &&
        !$past(alert_portion, PORTION_CYC + 1))
        else $error("alert portion width wrong");
    frame_len_a: assert property ($fell(alert_portion) |-> ##GAP
        (alert_portion || !fault_pin)) else $error("frame period wrong");
endmodule
bind tsff_top tsff_assertions #(.PWM_CH(PWM_CH),
    .PORTION_CYC(PORTION_CYC)) chk (.sys_clk, .rst_n,
    .internal_supply_valid, .enable_ch1, .enable_ch2, .temp_above_trip,
    .temp_below_recover, .pwm_oe, .die_overheat_shutdown,
    .power_up_restart, .fault_pin, .alert_portion);
`default_nettype wire

/* File: tb/tsff_top_test.sv */
// Testbench for the shutdown and fault frame block
`default_nettype none
module tsff_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst_n, supply, en1, en2, trip, below, f1, f2, pg;
    logic [3:0] pwm_in, pwm_out, pwm_oe;
    logic shut, restart, pin, alert;
    logic [11:0] mon_frame;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    tsff_top #(.PWM_CH(4), .PORTION_CYC(4)) uut (.sys_clk, .rst_n,
        .internal_supply_valid(supply), .enable_ch1(en1), .enable_ch2(en2),
        .temp_above_trip(trip), .temp_below_recover(below), .fault_ch1(f1),
        .fault_ch2(f2), .power_good_out(pg), .pwm_in, .pwm_out, .pwm_oe,
        .die_overheat_shutdown(shut), .power_up_restart(restart),
        .fault_pin(pin), .alert_portion(alert));
    tsff_monitor mon (.sys_clk, .fault_pin(pin), .frame(mon_frame));
    // Comparison and verdict
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (mismatches == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Disarmed, trip, recovery with restart pulse
    task automatic thermal_test();
        int seen;
        seen = 0;
        chk(pwm_oe, 4'hf);
        chk(pwm_out, 4'ha);
        supply = 0; trip = 1; below = 0;
        repeat (6) @(negedge sys_clk);
        chk(shut, 1'b0);
        supply = 1;
        repeat (6) @(negedge sys_clk);
        chk(shut, 1'b1);
        chk(pwm_oe, 4'h0);
        chk(pwm_out, 4'h0);
        trip = 0; below = 1;
        repeat (8) begin
            @(negedge sys_clk);
            if (restart === 1'b1) seen++;
        end
        chk(12'(seen), 12'h001);
        chk(shut, 1'b0);
        chk(pwm_oe, 4'hf);
    endtask
    // One channel faulting: frame, stop mid-frame, idle
    task automatic frame_test(input logic ch2, input logic [11:0] exp);
        int n;
        n = 0;
        pg = 0; f1 = !ch2; f2 = ch2;
        while (alert !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (12) @(posedge sys_clk);
        #1 chk(mon_frame, exp);
        repeat (5) @(negedge sys_clk);
        f1 = 0; f2 = 0; pg = 1;
        repeat (8) @(posedge sys_clk);
        #1 chk(mon_frame, exp);
        repeat (12) @(posedge sys_clk);
        #1 chk(mon_frame, 12'h000);
        @(negedge sys_clk);
    endtask
    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        rst_n = 0; supply = 1; en1 = 1; en2 = 0; trip = 0; below = 1;
        f1 = 0; f2 = 0; pg = 1; pwm_in = 4'ha;
        repeat (20) @(negedge sys_clk);
        rst_n = 1;
        repeat (4) @(negedge sys_clk);
        thermal_test();
        frame_test(1'b1, 12'hf0f);
        frame_test(1'b0, 12'hff0);
        close_out();
    end
endmodule
`default_nettype wire
